/* core/etp_top.sv */
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - one interrupt, two conversion start outputs
// - period: none, every one, two, three
// - selector picks one of six events
// - events count up to period, then stop
// - count readable, cleared on pulse or period write
// - enabled, flag clear: pulse, flag, restart
// - disabled, or interrupt path flagged: hold at period
// - flagged: interrupt pends until flag cleared
// - period write clears count, no pulse
// - force bit counts like real event
// - period zero disables counting and force
// - conversion path pulses despite set flag
// - conversion disable stops pulses, counting continues
// - independent six-source selectors for a, b
// - path b works like path a, with its own select and period
// - flags show events, clear register resets
// - force register injects into every path
// - direction qualifies compare matches up/down
module etp_top (
  // system
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // time-base and compare events
  input  wire logic        tb_zero_in,
  input  wire logic        tb_period_in,
  input  wire logic        cmp_a_match_in,
  input  wire logic        cmp_b_match_in,
  input  wire logic        tb_count_up_in,
  // trigger outputs
  output logic             irq_out,
  output logic             conv_start_a_out,
  output logic             conv_start_b_out
);

  etp_pkg::etp_bus_e bus_state_reg;
  logic [31:0]       readdata_reg;
  logic [15:0]       select_reg;
  logic [1:0]        period_reg [etp_pkg::PATHS];
  logic [1:0]        count_w    [etp_pkg::PATHS];
  logic              flag_w     [etp_pkg::PATHS];
  logic              pulse_w    [etp_pkg::PATHS];
  logic [5:0]        idx;
  logic              req;
  logic              wr_go;
  logic              rd_take;
  logic [5:0]        events;
  logic [15:0]       prescale_view;
  logic [15:0]       flags_view;
  logic [31:0]       read_word;

  etp_path_if path_bus [etp_pkg::PATHS] ();

  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic etp_hit(input logic [5:0] at, input logic [5:0] want);
    etp_hit = (at == want);
  endfunction

  function automatic logic etp_pick(input logic [2:0] src, input logic [5:0] ev);
    logic r;
    r = 1'b0;
    unique case (etp_pkg::etp_src_e'(src))
      etp_pkg::ETP_SRC_NONE:   r = 1'b0;
      etp_pkg::ETP_SRC_ZERO:   r = ev[0];
      etp_pkg::ETP_SRC_PERIOD: r = ev[1];
      etp_pkg::ETP_SRC_A_UP:   r = ev[2];
      etp_pkg::ETP_SRC_A_DOWN: r = ev[3];
      etp_pkg::ETP_SRC_B_UP:   r = ev[4];
      etp_pkg::ETP_SRC_B_DOWN: r = ev[5];
      etp_pkg::ETP_SRC_RSVD:   r = 1'b0;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // event qualification by count direction
  assign events = {cmp_b_match_in && !tb_count_up_in,
                   cmp_b_match_in &&  tb_count_up_in,
                   cmp_a_match_in && !tb_count_up_in,
                   cmp_a_match_in &&  tb_count_up_in,
                   tb_period_in,
                   tb_zero_in};

  ////////////////////////////////////////////////////////////////////////
  // avalon-mm handshake: one wait cycle, then answer
  assign idx                 = avs_address_in[7:2];
  assign req                 = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = req && (bus_state_reg == etp_pkg::ETP_BUS_IDLE);
  assign wr_go               = avs_write_in && (bus_state_reg == etp_pkg::ETP_BUS_ANSWER);
  assign rd_take             = avs_read_in && (bus_state_reg == etp_pkg::ETP_BUS_IDLE);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      bus_state_reg <= etp_pkg::ETP_BUS_IDLE;
    else
    begin
      unique case (bus_state_reg)
        etp_pkg::ETP_BUS_IDLE:   bus_state_reg <= req ? etp_pkg::ETP_BUS_ANSWER : etp_pkg::ETP_BUS_IDLE;
        etp_pkg::ETP_BUS_ANSWER: bus_state_reg <= etp_pkg::ETP_BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      readdata_reg <= 32'h0000_0000;
    else if (rd_take)
      readdata_reg <= read_word;
  end

  assign avs_readdata_out = readdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    prescale_view = 16'h0000;
    flags_view    = 16'h0000;
    for (int k = 0; k < etp_pkg::PATHS; k++)
    begin
      prescale_view[etp_pkg::PRD_LSB[k] +: etp_pkg::CNT_W] = period_reg[k];
      prescale_view[etp_pkg::PRD_LSB[k] + etp_pkg::CNT_OFS +: etp_pkg::CNT_W] = count_w[k];
      flags_view[etp_pkg::FLAG_BIT[k]] = flag_w[k];
    end
  end

  always_comb
  begin
    read_word = 32'h0000_0000;
    if (etp_hit(idx, etp_pkg::IDX_SELECT))
      read_word = {16'h0000, select_reg};
    else if (etp_hit(idx, etp_pkg::IDX_PRESCALE))
      read_word = {16'h0000, prescale_view};
    else if (etp_hit(idx, etp_pkg::IDX_FLAGS))
      read_word = {16'h0000, flags_view};
    else
      read_word = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // event_source_select register
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      select_reg <= etp_pkg::SELECT_RST;
    else if (wr_go && etp_hit(idx, etp_pkg::IDX_SELECT))
    begin
      if (avs_byteenable_in[0])
        select_reg[7:0] <= avs_writedata_in[7:0];
      if (avs_byteenable_in[1])
        select_reg[15:8] <= avs_writedata_in[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one prescale path per output
  for (genvar i = 0; i < etp_pkg::PATHS; i++)
  begin : g_path
    localparam int PL = etp_pkg::PRD_LSB[i];
    localparam int SL = etp_pkg::SRC_LSB[i];
    localparam int FB = etp_pkg::FLAG_BIT[i];
    logic prd_wr;

    assign prd_wr = wr_go && etp_hit(idx, etp_pkg::IDX_PRESCALE) && avs_byteenable_in[PL / 8];

    always_ff @(posedge clk_sys_in)
    begin
      if (rst_in)
        period_reg[i] <= etp_pkg::PERIOD_RST;
      else if (prd_wr)
        period_reg[i] <= avs_writedata_in[PL +: etp_pkg::CNT_W];
    end

    assign path_bus[i].period    = period_reg[i];
    assign path_bus[i].period_wr = prd_wr;
    assign path_bus[i].enable    = select_reg[SL + etp_pkg::EN_OFS];
    assign path_bus[i].event_hit = etp_pick(select_reg[SL +: etp_pkg::SRC_W], events);
    assign path_bus[i].clear_hit = wr_go && etp_hit(idx, etp_pkg::IDX_CLEAR)
                                   && avs_byteenable_in[FB / 8] && avs_writedata_in[FB];
    assign path_bus[i].force_hit = wr_go && etp_hit(idx, etp_pkg::IDX_FORCE)
                                   && avs_byteenable_in[FB / 8] && avs_writedata_in[FB];
    assign count_w[i] = path_bus[i].count;
    assign flag_w[i]  = path_bus[i].flag;
    assign pulse_w[i] = path_bus[i].pulse;

    etp_path #(
      .IRQ_MODE (i == etp_pkg::PATH_IRQ)
    ) u_path (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .bus        (path_bus[i].path)
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign irq_out          = pulse_w[etp_pkg::PATH_IRQ];
  assign conv_start_a_out = pulse_w[etp_pkg::PATH_A];
  assign conv_start_b_out = pulse_w[etp_pkg::PATH_B];

  ////////////////////////////////////////////////////////////////////////
  // checks
  bus_answer_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  write_only_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rd_take && (etp_hit(idx, etp_pkg::IDX_CLEAR) || etp_hit(idx, etp_pkg::IDX_FORCE))
    |=> avs_readdata_out == 32'h0000_0000)
    else $error("clear or force read nonzero");
  source_pick_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (select_reg[etp_pkg::SRC_LSB[0] +: 3] == 3'h1) && !tb_zero_in |-> !path_bus[0].event_hit)
    else $error("wrong interrupt source");
  dir_qualify_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (select_reg[etp_pkg::SRC_LSB[1] +: 3] == 3'h3) && !tb_count_up_in |-> !path_bus[1].event_hit)
    else $error("down match taken as up");
  clear_zero_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_go && etp_hit(idx, etp_pkg::IDX_CLEAR) && !avs_writedata_in[0] && flag_w[etp_pkg::PATH_IRQ]
    |=> flag_w[etp_pkg::PATH_IRQ])
    else $error("zero clear bit cleared flag");
  force_step_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_go && etp_hit(idx, etp_pkg::IDX_FORCE) && avs_writedata_in[0]
    && (period_reg[etp_pkg::PATH_IRQ] != 2'h0) && (count_w[etp_pkg::PATH_IRQ] < period_reg[etp_pkg::PATH_IRQ])
    |=> count_w[etp_pkg::PATH_IRQ] == 2'($past(count_w[etp_pkg::PATH_IRQ]) + 2'h1))
    else $error("force did not count");
  force_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_go && etp_hit(idx, etp_pkg::IDX_FORCE) && (period_reg[etp_pkg::PATH_A] == 2'h0)
    |=> (count_w[etp_pkg::PATH_A] == 2'h0) && !conv_start_a_out)
    else $error("force counted with zero period");
  period_load_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    wr_go && etp_hit(idx, etp_pkg::IDX_PRESCALE) && avs_byteenable_in[0]
    |=> period_reg[etp_pkg::PATH_IRQ] == $past(avs_writedata_in[1:0]))
    else $error("interrupt period not loaded");

  irq_pulse_c: cover property (@(posedge clk_sys_in) disable iff (rst_in) irq_out);
  both_starts_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    conv_start_a_out && conv_start_b_out);
  read_flags_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    rd_take && etp_hit(idx, etp_pkg::IDX_FLAGS));

endmodule
`default_nettype wire

/* core/etp_pkg.sv */
package etp_pkg;
  // bus shape
  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 32;
  localparam int          REG_W  = 16;
  // register indexes, byte address is four times the index
  localparam logic [5:0]  IDX_SELECT   = 6'h19;
  localparam logic [5:0]  IDX_PRESCALE = 6'h1a;
  localparam logic [5:0]  IDX_FLAGS    = 6'h1b;
  localparam logic [5:0]  IDX_CLEAR    = 6'h1c;
  localparam logic [5:0]  IDX_FORCE    = 6'h1d;
  // paths: interrupt, conversion start a, conversion start b
  localparam int          PATHS    = 3;
  localparam int          PATH_IRQ = 0;
  localparam int          PATH_A   = 1;
  localparam int          PATH_B   = 2;
  // event_source_select: 3-bit source at SRC_LSB, enable just above it
  localparam int          SRC_LSB [PATHS] = '{0, 8, 12};
  localparam int          SRC_W           = 3;
  localparam int          EN_OFS          = 3;
  // event_prescale: 2-bit period at PRD_LSB, 2-bit count just above it
  localparam int          PRD_LSB [PATHS] = '{0, 8, 12};
  localparam int          CNT_W           = 2;
  localparam int          CNT_OFS         = 2;
  // event_flags, event_flag_clear, event_force bit positions
  localparam int          FLAG_BIT [PATHS] = '{0, 2, 3};
  // reset values
  localparam logic [15:0] SELECT_RST = 16'h0000;
  localparam logic [1:0]  PERIOD_RST = 2'h0;
  localparam logic [1:0]  COUNT_RST  = 2'h0;
  // event sources
  typedef enum logic [2:0] {
    ETP_SRC_NONE   = 3'h0,
    ETP_SRC_ZERO   = 3'h1,
    ETP_SRC_PERIOD = 3'h2,
    ETP_SRC_A_UP   = 3'h3,
    ETP_SRC_A_DOWN = 3'h4,
    ETP_SRC_B_UP   = 3'h5,
    ETP_SRC_B_DOWN = 3'h6,
    ETP_SRC_RSVD   = 3'h7
  } etp_src_e;
  // bus answer states
  typedef enum logic {
    ETP_BUS_IDLE   = 1'b0,
    ETP_BUS_ANSWER = 1'b1
  } etp_bus_e;
endpackage

/* core/etp_path_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface etp_path_if;
  logic       event_hit;
  logic       force_hit;
  logic       clear_hit;
  logic       period_wr;
  logic       enable;
  logic [1:0] period;
  logic [1:0] count;
  logic       flag;
  logic       pulse;
  modport ctrl (output event_hit, force_hit, clear_hit, period_wr, enable, period,
                input  count, flag, pulse);
  modport path (input  event_hit, force_hit, clear_hit, period_wr, enable, period,
                output count, flag, pulse);
endinterface
`default_nettype wire

/* core/etp_path.sv */
`timescale 1ns/1ps
`default_nettype none
module etp_path #(
  parameter bit IRQ_MODE = 1'b1
) (
  // system
  input  wire logic clk_sys_in,
  input  wire logic rst_in,
  // control and status
  etp_path_if.path  bus
);

  logic [1:0] count_reg;
  logic       flag_reg;
  logic       pulse_reg;
  logic       armed;
  logic       step;
  logic       full;
  logic       fire;

  ////////////////////////////////////////////////////////////////////////
  // prescale counter
  assign armed = (bus.period != etp_pkg::PERIOD_RST);
  assign step  = armed && (bus.event_hit || bus.force_hit);
  assign full  = armed && (count_reg == bus.period);
  assign fire  = full && bus.enable && (!IRQ_MODE || !flag_reg);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      count_reg <= etp_pkg::COUNT_RST;
    else if (bus.period_wr)
      count_reg <= etp_pkg::COUNT_RST;
    else if (fire)
      count_reg <= etp_pkg::COUNT_RST;
    else if (step && !full)
      count_reg <= 2'(count_reg + 2'h1);
  end

  ////////////////////////////////////////////////////////////////////////
  // flag and pulse, set wins over clear
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      flag_reg <= 1'b0;
    else
      flag_reg <= (fire && !bus.period_wr) || (flag_reg && !bus.clear_hit);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      pulse_reg <= 1'b0;
    else
      pulse_reg <= fire && !bus.period_wr;
  end

  assign bus.count = count_reg;
  assign bus.flag  = flag_reg;
  assign bus.pulse = pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  pulse_one_cycle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    bus.pulse |=> !bus.pulse)
    else $error("pulse longer than one cycle");
  pulse_sets_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    bus.pulse |-> bus.flag)
    else $error("pulse without flag");
  count_in_range_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    bus.count <= bus.period)
    else $error("count passed period");
  period_write_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    bus.period_wr |=> (bus.count == 2'h0) && !bus.pulse)
    else $error("period write did not clear count");
  zero_period_idle_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (bus.period == 2'h0) [*2] |-> !bus.pulse && (bus.count == 2'h0))
    else $error("disabled counter active");
  irq_hold_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    IRQ_MODE && full && bus.flag && !bus.clear_hit && !bus.period_wr |=> full && !bus.pulse)
    else $error("held interrupt count moved");
  irq_pending_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (IRQ_MODE && full && bus.enable && bus.flag && bus.clear_hit && !bus.period_wr
     ##1 (bus.enable && !bus.period_wr)) |=> bus.pulse)
    else $error("pending interrupt not issued");
  soc_repeat_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !IRQ_MODE && full && bus.enable && !bus.period_wr |=> bus.pulse)
    else $error("conversion pulse missing");
  disabled_quiet_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !bus.enable |=> !bus.pulse)
    else $error("pulse while disabled");

  pulse_seen_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    bus.pulse ##1 !bus.pulse [*2] ##1 bus.pulse);
  held_then_clear_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
    full && bus.flag ##1 bus.clear_hit ##2 bus.pulse);

endmodule
`default_nettype wire

/* bench/etp_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
module etp_far_model (
  // system
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // trigger lines from the block
  input  wire logic       irq_in,
  input  wire logic       conv_start_a_in,
  input  wire logic       conv_start_b_in,
  // requests seen by expander and sequencers
  output logic      [7:0] irq_count_out,
  output logic      [7:0] conv_a_count_out,
  output logic      [7:0] conv_b_count_out,
  output logic            wide_out
);
  logic [2:0] last_reg;
  ////////////////////////////////////////////////////////////////
  // a held level counts as one request on each line
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      last_reg         <= 3'h0;
      irq_count_out    <= 8'h00;
      conv_a_count_out <= 8'h00;
      conv_b_count_out <= 8'h00;
      wide_out         <= 1'b0;
    end
    else
    begin
      last_reg <= {conv_start_b_in, conv_start_a_in, irq_in};
      if (irq_in && !last_reg[0])
        irq_count_out <= irq_count_out + 8'h01;
      if (conv_start_a_in && !last_reg[1])
        conv_a_count_out <= conv_a_count_out + 8'h01;
      if (conv_start_b_in && !last_reg[2])
        conv_b_count_out <= conv_b_count_out + 8'h01;
      if ((last_reg & {conv_start_b_in, conv_start_a_in, irq_in}) != 3'h0)
        wide_out <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [2:0] src;
    logic [1:0] prd;
    logic [3:0] n;
    logic [7:0] e_irq;
    logic [7:0] e_conv;
    logic [1:0] e_icnt;
    logic [1:0] e_ccnt;
  } etp_row_s;
  logic        clk_sys_in;
  logic        rst_in;
  logic [7:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  logic [3:0]  ev_in;
  logic        up_in;
  logic        irq_out;
  logic        ca_out;
  logic        cb_out;
  logic [7:0]  n_irq;
  logic [7:0]  n_ca;
  logic [7:0]  n_cb;
  logic [7:0]  b_irq;
  logic [7:0]  b_ca;
  logic [7:0]  b_cb;
  logic        wide;
  logic [15:0] rdat;
  logic [15:0] sel;
  logic [15:0] prs;
  etp_row_s    r;
  int          err_count;
  int          cmp_count;
  etp_row_s    rows [8] = '{
    '{3'h1, 2'h1, 4'h3, 8'h01, 8'h03, 2'h1, 2'h0},
    '{3'h2, 2'h2, 4'h5, 8'h01, 8'h02, 2'h2, 2'h1},
    '{3'h3, 2'h3, 4'h7, 8'h01, 8'h02, 2'h3, 2'h1},
    '{3'h4, 2'h1, 4'h2, 8'h01, 8'h02, 2'h1, 2'h0},
    '{3'h5, 2'h2, 4'h4, 8'h01, 8'h02, 2'h2, 2'h0},
    '{3'h6, 2'h3, 4'h3, 8'h01, 8'h01, 2'h0, 2'h0},
    '{3'h1, 2'h0, 4'h3, 8'h00, 8'h00, 2'h0, 2'h0},
    '{3'h6, 2'h2, 4'h1, 8'h00, 8'h00, 2'h1, 2'h1}};
  ////////////////////////////////////////////////////////////////
  etp_top i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .tb_zero_in(ev_in[0]), .tb_period_in(ev_in[1]),
    .cmp_a_match_in(ev_in[2]), .cmp_b_match_in(ev_in[3]), .tb_count_up_in(up_in),
    .irq_out(irq_out), .conv_start_a_out(ca_out), .conv_start_b_out(cb_out));
  etp_far_model i_far (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .irq_in(irq_out),
    .conv_start_a_in(ca_out), .conv_start_b_in(cb_out), .irq_count_out(n_irq),
    .conv_a_count_out(n_ca), .conv_b_count_out(n_cb), .wide_out(wide));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h want %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] d);
    int i;
    @(posedge clk_sys_in);
    avs_address_in   <= {idx, 2'h0};
    avs_writedata_in <= {16'h0000, d};
    avs_write_in     <= wr;
    avs_read_in      <= ~wr;
    i = 0;
    @(posedge clk_sys_in);
    while (avs_waitrequest_out !== 1'b0 && i < 20)
    begin
      @(posedge clk_sys_in);
      i++;
    end
    if (i >= 20)
    begin
      $display("BAD %0t bus answer missing", $time);
      err_count++;
      results();
    end
    rdat = avs_readdata_out[15:0];
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
  endtask
  task automatic ev(input logic [2:0] s);
    @(posedge clk_sys_in);
    ev_in <= (s == 3'h1) ? 4'h1 : (s == 3'h2) ? 4'h2 : (s < 3'h5) ? 4'h4 : 4'h8;
    up_in <= s[0];
    @(posedge clk_sys_in);
    ev_in <= 4'h0;
  endtask
  function automatic logic [2:0] decoy(input logic [2:0] s);
    return (s < 3'h3) ? 3'h3 - s : (s[0] ? s + 3'h1 : s - 3'h1);
  endfunction
  task automatic snap();
    b_irq = n_irq;
    b_ca  = n_ca;
    b_cb  = n_cb;
  endtask
  task automatic pc(input logic [7:0] ei, input logic [7:0] ea, input logic [7:0] eb);
    repeat (3) @(posedge clk_sys_in);
    chk({8'h00, n_irq - b_irq}, {8'h00, ei});
    chk({8'h00, n_ca - b_ca}, {8'h00, ea});
    chk({8'h00, n_cb - b_cb}, {8'h00, eb});
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_in = 1'b1;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'h3;
    ev_in = 4'h0;
    up_in = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    foreach (rows[k])
    begin
      r = rows[k];
      sel = {1'b1, r.src, 1'b1, r.src, 4'h0, 1'b1, r.src};
      prs = {2'h0, r.prd, 2'h0, r.prd, 6'h00, r.prd};
      bus(1'b1, etp_pkg::IDX_SELECT, sel);
      bus(1'b0, etp_pkg::IDX_SELECT, 16'h0000);
      chk(rdat, sel);
      bus(1'b1, etp_pkg::IDX_PRESCALE, prs);
      bus(1'b1, etp_pkg::IDX_CLEAR, 16'h000d);
      snap();
      for (int j = 0; j < r.n; j++)
      begin
        ev(decoy(r.src));
        ev(r.src);
      end
      pc(r.e_irq, r.e_conv, r.e_conv);
      bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
      chk(rdat, {r.e_ccnt, r.prd, r.e_ccnt, r.prd, 4'h0, r.e_icnt, r.prd});
      bus(1'b0, etp_pkg::IDX_FLAGS, 16'h0000);
      chk(rdat, {12'h000, r.e_conv != 0, r.e_conv != 0, 1'b0, r.e_irq[0]});
      $display("row %0d done", k);
    end
    bus(1'b1, etp_pkg::IDX_SELECT, 16'h0009);
    bus(1'b1, etp_pkg::IDX_PRESCALE, 16'h0001);
    bus(1'b1, etp_pkg::IDX_CLEAR, 16'h000d);
    snap();
    ev(3'h1);
    ev(3'h1);
    pc(8'h01, 8'h00, 8'h00);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h0005);
    bus(1'b1, etp_pkg::IDX_CLEAR, 16'h0001);
    pc(8'h02, 8'h00, 8'h00);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h0001);
    $display("pending test done");
    bus(1'b1, etp_pkg::IDX_SELECT, 16'h1101);
    bus(1'b1, etp_pkg::IDX_PRESCALE, 16'h2202);
    snap();
    repeat (3) ev(3'h1);
    pc(8'h00, 8'h00, 8'h00);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'haa0a);
    bus(1'b1, etp_pkg::IDX_PRESCALE, 16'h2202);
    bus(1'b1, etp_pkg::IDX_SELECT, 16'h9909);
    pc(8'h00, 8'h00, 8'h00);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h2202);
    $display("hold test done");
    bus(1'b1, etp_pkg::IDX_CLEAR, 16'h000d);
    bus(1'b1, etp_pkg::IDX_FORCE, 16'h000d);
    bus(1'b1, etp_pkg::IDX_FORCE, 16'h0000);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h6606);
    bus(1'b1, etp_pkg::IDX_FORCE, 16'h000d);
    pc(8'h01, 8'h01, 8'h01);
    bus(1'b1, etp_pkg::IDX_CLEAR, 16'h0000);
    bus(1'b0, etp_pkg::IDX_FLAGS, 16'h0000);
    chk(rdat, 16'h000d);
    bus(1'b0, etp_pkg::IDX_FORCE, 16'h0000);
    chk(rdat, 16'h0000);
    bus(1'b0, etp_pkg::IDX_CLEAR, 16'h0000);
    chk(rdat, 16'h0000);
    bus(1'b0, 6'h20, 16'h0000);
    chk(rdat, 16'h0000);
    bus(1'b1, etp_pkg::IDX_PRESCALE, 16'h0000);
    bus(1'b1, etp_pkg::IDX_FORCE, 16'h000d);
    pc(8'h01, 8'h01, 8'h01);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h0000);
    $display("force test done");
    chk({15'h0000, wide}, 16'h0000);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    chk({13'h0000, irq_out, ca_out, cb_out}, 16'h0000);
    bus(1'b0, etp_pkg::IDX_SELECT, 16'h0000);
    chk(rdat, etp_pkg::SELECT_RST);
    bus(1'b0, etp_pkg::IDX_PRESCALE, 16'h0000);
    chk(rdat, 16'h0000);
    bus(1'b0, etp_pkg::IDX_FLAGS, 16'h0000);
    chk(rdat, 16'h0000);
    $display("reset test done");
    results();
  end
endmodule
`default_nettype wire
